// ==== wit_pkg.sv ====
// constants, types and reset values of the watchdog / interval timer
package wit_pkg;

   // -------------------------------------------------------------------
   // register map (index; byte address is four times the index)
   // -------------------------------------------------------------------
   localparam int ADDR_W = 18;
   localparam logic [15:0] IDX_CLK_SEL = 16'hff42;
   localparam logic [15:0] IDX_MODE = 16'hfff9;
   localparam logic [15:0] IDX_IRQ = 16'hff40;
   localparam logic [7:0] CLK_SEL_RST = 8'h00;
   localparam logic [7:0] MODE_REG_RST = 8'h00;

   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int CLK_SEL_LSB = 1;
   localparam int RUN_BIT = 7;
   localparam int MODE_LO_BIT = 3;
   localparam int FLAG_BIT = 0;
   localparam int MASK_BIT = 1;
   localparam int CNT_LSB = 8;

   // -------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------
   localparam int PRE_W = 10;
   localparam int CNT_W = 7;
   localparam logic [CNT_W-1:0] CNT_MAX = 7'h7f;
   localparam logic [PRE_W-1:0] DIV_MASK_0 = 10'h00f;
   localparam logic [PRE_W-1:0] DIV_MASK_1 = 10'h03f;
   localparam logic [PRE_W-1:0] DIV_MASK_2 = 10'h0ff;
   localparam logic [PRE_W-1:0] DIV_MASK_3 = 10'h3ff;

   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_IVL = 2'b01,
      MODE_NMI = 2'b10,
      MODE_RST = 2'b11
   } wit_mode_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } wit_bus_st_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } wit_avs_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } wit_avs_rsp_t;

   typedef struct packed {
      wit_bus_st_t bus;
      logic [15:0] rdata;
      logic [1:0] clk_sel;
      logic run;
      logic [1:0] mode;
      logic wdog_irq_flag;
      logic wdog_irq_mask;
      logic [PRE_W-1:0] presc;
      logic [CNT_W-1:0] cnt;
      logic nmi;
      logic rst_req;
      logic ivl;
   } wit_state_t;

   localparam wit_state_t ST_RESET = '{
      bus: BUS_IDLE, rdata: 16'h0000, clk_sel: CLK_SEL_RST[2:1],
      run: MODE_REG_RST[RUN_BIT], mode: MODE_REG_RST[MODE_LO_BIT +: 2], wdog_irq_flag: 1'b0,
      wdog_irq_mask: 1'b1, presc: 10'h000, cnt: 7'h00,
      nmi: 1'b0, rst_req: 1'b0, ivl: 1'b0};

endpackage

// ==== wit_top.sv ====
// watchdog / interval timer with avalon-mm register slave
`timescale 1ns/1ns
module wit_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire wit_pkg::wit_avs_req_t avs_req_i,
   output wit_pkg::wit_avs_rsp_t avs_rsp_o,
   input wire logic stop_mode_i,
   input wire logic sub_clk_cpu_i,
   output logic nmi_o,
   output logic sys_reset_o,
   output logic interval_irq_o
);

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   wit_pkg::wit_state_t s_r;
   wit_pkg::wit_state_t s_nxt;

   logic req;
   logic take;
   logic hit_clk;
   logic hit_mode;
   logic hit_irq;
   logic wr_ok;
   logic mode_wr;
   logic run_wr;
   logic halt;
   logic cnt_en;
   logic tick;
   logic ovf;
   logic [wit_pkg::PRE_W-1:0] div_mask;
   logic [15:0] rd_mux;

   // -------------------------------------------------------------------
   // bus decode
   // -------------------------------------------------------------------
   assign req = avs_req_i.read | avs_req_i.write;
   assign take = req & (s_r.bus == wit_pkg::BUS_ACK);
   assign wr_ok = take & avs_req_i.write & avs_req_i.byteenable[0];

   always_comb begin
      hit_clk = 1'b0;
      hit_mode = 1'b0;
      hit_irq = 1'b0;
      if (avs_req_i.address == {wit_pkg::IDX_CLK_SEL, 2'b00}) begin
         hit_clk = 1'b1;
      end else if (avs_req_i.address == {wit_pkg::IDX_MODE, 2'b00}) begin
         hit_mode = 1'b1;
      end else if (avs_req_i.address == {wit_pkg::IDX_IRQ, 2'b00}) begin
         hit_irq = 1'b1;
      end
   end

   assign mode_wr = wr_ok & hit_mode;
   assign run_wr = mode_wr & avs_req_i.writedata[wit_pkg::RUN_BIT];

   always_comb begin
      rd_mux = 16'h0000;
      if (hit_clk) begin
         rd_mux[wit_pkg::CLK_SEL_LSB +: 2] = s_r.clk_sel;
      end else if (hit_mode) begin
         rd_mux[wit_pkg::RUN_BIT] = s_r.run;
         rd_mux[wit_pkg::MODE_LO_BIT +: 2] = s_r.mode;
      end else if (hit_irq) begin
         rd_mux[wit_pkg::FLAG_BIT] = s_r.wdog_irq_flag;
         rd_mux[wit_pkg::MASK_BIT] = s_r.wdog_irq_mask;
         rd_mux[wit_pkg::CNT_LSB +: wit_pkg::CNT_W] = s_r.cnt;
      end
   end

   // -------------------------------------------------------------------
   // count clock
   // -------------------------------------------------------------------
   always_comb begin
      case (s_r.clk_sel)
         2'b00: div_mask = wit_pkg::DIV_MASK_0;
         2'b01: div_mask = wit_pkg::DIV_MASK_1;
         2'b10: div_mask = wit_pkg::DIV_MASK_2;
         default: div_mask = wit_pkg::DIV_MASK_3;
      endcase
   end

   // main clock to the timer is gated off in stop and on subsystem clock
   assign halt = stop_mode_i | sub_clk_cpu_i;
   assign tick = ~halt & ((s_r.presc & div_mask) == div_mask);
   assign cnt_en = s_r.run & (s_r.mode != wit_pkg::MODE_OFF);
   assign ovf = cnt_en & tick & (s_r.cnt == wit_pkg::CNT_MAX);

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.nmi = 1'b0;
      s_nxt.rst_req = 1'b0;
      s_nxt.ivl = 1'b0;

      case (s_r.bus)
         wit_pkg::BUS_IDLE: begin
            if (req) begin
               s_nxt.bus = wit_pkg::BUS_ACK;
               s_nxt.rdata = rd_mux;
            end
         end
         wit_pkg::BUS_ACK: begin
            s_nxt.bus = wit_pkg::BUS_IDLE;
         end
         default: begin
            s_nxt.bus = wit_pkg::BUS_IDLE;
         end
      endcase

      // free running, never cleared by a restart
      if (!halt) begin
         s_nxt.presc = s_r.presc + 10'h001;
      end

      if (s_r.mode == wit_pkg::MODE_OFF) begin
         s_nxt.cnt = '0;
      end else if (cnt_en && tick) begin
         s_nxt.cnt = s_r.cnt + 7'h01;
      end

      if (ovf) begin
         case (s_r.mode)
            wit_pkg::MODE_IVL: s_nxt.ivl = ~s_r.wdog_irq_mask;
            wit_pkg::MODE_NMI: s_nxt.nmi = 1'b1;
            wit_pkg::MODE_RST: s_nxt.rst_req = 1'b1;
            default: s_nxt.ivl = 1'b0;
         endcase
      end

      if (wr_ok && hit_clk) begin
         s_nxt.clk_sel = avs_req_i.writedata[wit_pkg::CLK_SEL_LSB +: 2];
      end

      if (mode_wr) begin
         s_nxt.run = s_r.run | avs_req_i.writedata[wit_pkg::RUN_BIT];
         s_nxt.mode = s_r.mode
            | avs_req_i.writedata[wit_pkg::MODE_LO_BIT +: 2];
         if (s_nxt.mode[1] && s_r.wdog_irq_flag) begin
            s_nxt.nmi = 1'b1;
         end
      end

      if (run_wr) begin
         s_nxt.cnt = '0;
      end

      if (wr_ok && hit_irq) begin
         s_nxt.wdog_irq_mask = avs_req_i.writedata[wit_pkg::MASK_BIT];
         s_nxt.wdog_irq_flag = s_r.wdog_irq_flag
            & avs_req_i.writedata[wit_pkg::FLAG_BIT];
      end

      // an overflow in the clearing cycle still sets the flag
      if (ovf) begin
         s_nxt.wdog_irq_flag = 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= wit_pkg::ST_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign avs_rsp_o = '{readdata: {16'h0000, s_r.rdata},
      waitrequest: req & (s_r.bus != wit_pkg::BUS_ACK)};
   assign nmi_o = s_r.nmi;
   assign sys_reset_o = s_r.rst_req;
   assign interval_irq_o = s_r.ivl;

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_run_sticky: assert property (s_r.run |=> s_r.run)
      else $error("run bit cleared without reset");

   a_mode_sticky: assert property (
      (s_r.mode[0] |=> s_r.mode[0]) and (s_r.mode[1] |=> s_r.mode[1]))
      else $error("mode bit cleared without reset");

   a_cnt_off_zero: assert property (
      (s_r.mode == wit_pkg::MODE_OFF) |=> (s_r.cnt == 7'h00))
      else $error("counter moved in stopped mode");

   a_run_clears: assert property (run_wr |=> (s_r.cnt == 7'h00) && s_r.run)
      else $error("run write did not clear counter");

   a_stop_freeze: assert property (
      (stop_mode_i && !run_wr && s_r.mode != wit_pkg::MODE_OFF)
      |=> $stable(s_r.cnt) && $stable(s_r.presc))
      else $error("counter moved in stop");

   a_sub_freeze: assert property (
      (sub_clk_cpu_i && !run_wr && s_r.mode != wit_pkg::MODE_OFF)
      |=> $stable(s_r.cnt))
      else $error("counter moved on subsystem clock");

   a_tick_div: assert property (
      (cnt_en && !run_wr && s_r.cnt != wit_pkg::CNT_MAX)
      ##1 (s_r.cnt != $past(s_r.cnt))
      |-> ($past(s_r.presc & div_mask) == $past(div_mask)))
      else $error("counter stepped off a prescaler tick");

   a_ovf_reset: assert property (
      (ovf && s_r.mode == wit_pkg::MODE_RST)
      |=> sys_reset_o && !interval_irq_o ##1 !sys_reset_o)
      else $error("watchdog reset missing");

   a_ovf_nmi: assert property (
      (ovf && s_r.mode == wit_pkg::MODE_NMI) |=> nmi_o && !sys_reset_o)
      else $error("watchdog nmi missing");

   a_ivl_mask: assert property (
      interval_irq_o |-> $past(!s_r.wdog_irq_mask)
      && $past(s_r.mode) == wit_pkg::MODE_IVL)
      else $error("interval interrupt escaped its mask");

   a_no_run_irq: assert property (
      !s_r.run |=> !interval_irq_o && !nmi_o || $past(mode_wr))
      else $error("interrupt before run");

   a_mode_nmi: assert property (
      (mode_wr && s_nxt.mode[1] && s_r.wdog_irq_flag) |=> nmi_o)
      else $error("pending flag gave no nmi on mode write");

   a_flag_set: assert property (ovf |=> s_r.wdog_irq_flag)
      else $error("overflow lost its flag");

   a_bus_answer: assert property (req |-> ##[0:1] !avs_rsp_o.waitrequest)
      else $error("bus answer late");

   a_ivl_pulse: assert property (
      (ovf && s_r.mode == wit_pkg::MODE_IVL && !s_r.wdog_irq_mask) |=> interval_irq_o)
      else $error("unmasked interval overflow gave no interrupt");

   a_ivl_gated: assert property (
      (ovf && s_r.mode == wit_pkg::MODE_IVL && s_r.wdog_irq_mask) |=> !interval_irq_o)
      else $error("masked interval overflow raised an interrupt");

   a_ivl_single: assert property (interval_irq_o |=> !interval_irq_o)
      else $error("interval interrupt longer than one cycle");

   a_wd_no_ivl: assert property (s_r.mode[1] |=> !interval_irq_o)
      else $error("interval interrupt in watchdog mode");

   a_rst_cause: assert property (
      sys_reset_o |-> $past(ovf) && $past(s_r.mode) == wit_pkg::MODE_RST)
      else $error("reset request without watchdog overflow");

   a_nmi_cause: assert property (
      nmi_o |-> ($past(ovf) && $past(s_r.mode) == wit_pkg::MODE_NMI) || $past(mode_wr))
      else $error("nmi without overflow or mode write");

   a_halt_presc: assert property (halt |=> $stable(s_r.presc))
      else $error("prescaler moved while halted");

   a_presc_run: assert property (
      !halt |=> (s_r.presc == $past(s_r.presc) + 10'h001))
      else $error("prescaler did not advance");

   a_cnt_step: assert property (
      (tick && cnt_en && !run_wr && s_r.cnt != wit_pkg::CNT_MAX)
      |=> (s_r.cnt == $past(s_r.cnt) + 7'h01))
      else $error("counter missed a tick");

   a_cnt_wrap: assert property ((ovf && !run_wr) |=> (s_r.cnt == 7'h00))
      else $error("counter did not wrap on overflow");

   a_cnt_hold: assert property (
      (!tick && !run_wr && s_r.mode != wit_pkg::MODE_OFF) |=> $stable(s_r.cnt))
      else $error("counter moved without a tick");

   a_clk_sel_wr: assert property (
      (wr_ok && hit_clk)
      |=> (s_r.clk_sel == $past(avs_req_i.writedata[wit_pkg::CLK_SEL_LSB +: 2])))
      else $error("clock select write lost");

   a_clk_sel_hold: assert property (!(wr_ok && hit_clk) |=> $stable(s_r.clk_sel))
      else $error("clock select changed without a write");

   a_flag_clear: assert property (
      (wr_ok && hit_irq && !avs_req_i.writedata[wit_pkg::FLAG_BIT] && !ovf)
      |=> !s_r.wdog_irq_flag)
      else $error("flag clear write lost");

   a_flag_kept: assert property (
      (s_r.wdog_irq_flag && !(wr_ok && hit_irq)) |=> s_r.wdog_irq_flag)
      else $error("flag dropped without a write");

   a_read_data: assert property (
      (req && s_r.bus == wit_pkg::BUS_IDLE) |=> (avs_rsp_o.readdata[15:0] == $past(rd_mux)))
      else $error("read data not captured");

   a_ack_once: assert property (
      (s_r.bus == wit_pkg::BUS_ACK) |=> (s_r.bus == wit_pkg::BUS_IDLE))
      else $error("bus answer held too long");

   c_ivl_irq: cover property (interval_irq_o);
   c_wd_kick: cover property (s_r.mode[1] && run_wr);
   c_wd_reset: cover property (sys_reset_o);
   c_flag_race: cover property (ovf && wr_ok && hit_irq);
   c_mode_flag: cover property (mode_wr && s_nxt.mode[1] && s_r.wdog_irq_flag);

endmodule // wit_top

// ==== tb_watchdog_interval_timer.sv ====
// self-checking testbench of the watchdog / interval timer
`timescale 1ns/1ns
module tb_watchdog_interval_timer;
   // ------------------------------------------------------------
   // signals and counters
   // ------------------------------------------------------------
   localparam logic [17:0] A_SEL = 18'h3fd08;
   localparam logic [17:0] A_MODE = 18'h3ffe4;
   localparam logic [17:0] A_IRQ = 18'h3fd00;
   localparam logic [17:0] A_NONE = 18'h00010;
   logic clk_i;
   logic rst_i;
   wit_pkg::wit_avs_req_t req;
   wit_pkg::wit_avs_rsp_t rsp;
   logic stop_mode;
   logic sub_clk;
   logic nmi;
   logic srst;
   logic ivl;
   logic [31:0] rd;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cyc = 0;
   int n_nmi = 0;
   int n_rst = 0;
   int n_ivl = 0;
   int n;

   wit_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .avs_req_i(req), .avs_rsp_o(rsp),
      .stop_mode_i(stop_mode), .sub_clk_cpu_i(sub_clk), .nmi_o(nmi),
      .sys_reset_o(srst), .interval_irq_o(ivl));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // pulse counters and the run ceiling
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (nmi === 1'b1) n_nmi <= n_nmi + 1;
      if (srst === 1'b1) n_rst <= n_rst + 1;
      if (ivl === 1'b1) n_ivl <= n_ivl + 1;
      if (cyc == 70000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic end_of_test();
      $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic wr, input logic [17:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req.read <= ~wr;
      req.write <= wr;
      req.address <= a;
      req.writedata <= {24'h000000, d};
      req.byteenable <= 4'hf;
      @(posedge clk_i);
      while (rsp.waitrequest !== 1'b0) @(posedge clk_i);
      rd = rsp.readdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask

   function automatic int cnt_of(input int w);
      return (w == 0) ? n_nmi : (w == 1) ? n_rst : n_ivl;
   endfunction

   // edges until the chosen pulse counter moves, at most lim
   task automatic wait_cnt(input int w, input int lim, output int k);
      int b;
      b = cnt_of(w);
      k = 0;
      while (cnt_of(w) == b && k < lim) begin
         @(posedge clk_i);
         k++;
      end
   endtask

   task automatic do_reset();
      rst_i <= 1'b1;
      stop_mode <= 1'b0;
      sub_clk <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset_values();
      do_reset();
      bus(1'b0, A_SEL, 8'h00);
      check("clk sel reset", rd, 32'h00000000);
      bus(1'b0, A_MODE, 8'h00);
      check("mode reset", rd, 32'h00000000);
      bus(1'b0, A_IRQ, 8'h00);
      check("irq reset", rd, 32'h00000002);
      bus(1'b1, A_NONE, 8'hff);
      bus(1'b0, A_NONE, 8'h00);
      check("unmapped", rd, 32'h00000000);
      bus(1'b1, A_SEL, 8'h06);
      bus(1'b0, A_SEL, 8'h00);
      check("clk sel fields", rd, 32'h00000006);
   endtask

   task automatic t_interval();
      logic [31:0] c1;
      do_reset();
      bus(1'b1, A_MODE, 8'h08);
      wait_cnt(2, 3000, n);
      check("no count before run", n, 3000);
      bus(1'b0, A_IRQ, 8'h00);
      check("counter held", rd[14:8], 32'h0);
      bus(1'b1, A_IRQ, 8'h00);
      bus(1'b1, A_MODE, 8'h80);
      bus(1'b0, A_MODE, 8'h00);
      check("mode bit kept", rd, 32'h00000088);
      wait_cnt(2, 2100, n);
      check("first period short", (n > 1990 && n <= 2048), 1);
      wait_cnt(2, 2100, n);
      check("interval period", n, 2048);
      bus(1'b1, A_IRQ, 8'h02);
      wait_cnt(2, 2100, n);
      check("masked irq", n, 2100);
      bus(1'b0, A_IRQ, 8'h00);
      check("flag still set", rd[0], 1);
      bus(1'b1, A_MODE, 8'h00);
      bus(1'b0, A_MODE, 8'h00);
      check("run kept", rd, 32'h00000088);
      bus(1'b1, A_IRQ, 8'h00);
      bus(1'b1, A_MODE, 8'h80);
      stop_mode <= 1'b1;
      bus(1'b0, A_IRQ, 8'h00);
      c1 = rd;
      wait_cnt(2, 2100, n);
      bus(1'b0, A_IRQ, 8'h00);
      check("stop freezes", rd, c1);
      stop_mode <= 1'b0;
      sub_clk <= 1'b1;
      bus(1'b0, A_IRQ, 8'h00);
      c1 = rd;
      wait_cnt(2, 2100, n);
      check("sub clock no irq", n, 2100);
      bus(1'b0, A_IRQ, 8'h00);
      check("sub clock freezes", rd, c1);
      sub_clk <= 1'b0;
      wait_cnt(2, 2100, n);
      check("resumes", (n > 2030 && n <= 2050), 1);
   endtask

   task automatic t_watchdog();
      int b;
      int b_ivl;
      do_reset();
      b_ivl = n_ivl;
      bus(1'b1, A_SEL, 8'h02);
      bus(1'b0, A_IRQ, 8'h00);
      check("flag clear before wdog", rd[0], 1'b0);
      bus(1'b1, A_MODE, 8'h90);
      repeat (3) begin
         repeat (6000) @(posedge clk_i);
         bus(1'b1, A_MODE, 8'h80);
      end
      check("refresh keeps quiet", n_nmi, 0);
      wait_cnt(0, 8300, n);
      check("nmi period", (n > 8120 && n <= 8200), 1);
      check("no reset in nmi mode", n_rst, 0);
      b = n_nmi;
      bus(1'b1, A_MODE, 8'h80);
      @(posedge clk_i);
      #1;
      check("nmi on mode write", n_nmi, b + 1);
      bus(1'b1, A_IRQ, 8'h02);
      bus(1'b1, A_MODE, 8'h08);
      bus(1'b0, A_MODE, 8'h00);
      check("no interval after wdog", rd, 32'h00000098);
      wait_cnt(1, 8300, n);
      check("reset mode pulse", n_rst, 1);
      check("no interval irq", n_ivl - b_ivl, 0);
   endtask

   initial begin
      rst_i = 1'b1;
      req = '0;
      stop_mode = 1'b0;
      sub_clk = 1'b0;
      t_reset_values();
      t_interval();
      t_watchdog();
      end_of_test();
   end
endmodule // tb_watchdog_interval_timer
